// ===== pkg/lvd_pkg.sv
// constants and types for the low-voltage detect control block
package lvd_pkg;
    localparam int          LVD_AW            = 16;
    localparam logic [15:0] LVD_CTRL_ADDR     = 16'hff50;
    localparam logic [15:0] LVD_LEVEL_ADDR    = 16'hff51;
    localparam logic [15:0] LVD_IRQ_ADDR      = 16'hff52;
    localparam logic [15:0] LVD_CAUSE_ADDR    = 16'hff53;
    localparam int          LVD_CTRL_EN_BIT   = 7;
    localparam int          LVD_CTRL_ACT_BIT  = 1;
    localparam int          LVD_CTRL_FLAG_BIT = 0;
    localparam int          LVD_IRQ_PEND_BIT  = 0;
    localparam int          LVD_IRQ_MASK_BIT  = 1;
    localparam int          LVD_CAUSE_BIT     = 0;
    localparam logic [7:0]  LVD_CTRL_RST      = 8'h00;
    localparam logic [3:0]  LVD_LEVEL_RST     = 4'h0;
    localparam logic [3:0]  LVD_LEVEL_MAX     = 4'h9;
    localparam int          LVD_SETTLE_US     = 200;
    localparam int          LVD_CLK_MHZ       = 50;
    localparam int          LVD_SETTLE_CYC    = LVD_SETTLE_US * LVD_CLK_MHZ;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } lvd_bus_s;
endpackage

// ===== rtl/lvd_sync.sv
// two-flop synchroniser for the comparator level
`timescale 1ns/100ps
module lvd_sync (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ===== rtl/lvd_settle.sv
// settling counter started when the monitor is enabled
`timescale 1ns/100ps
module lvd_settle #(
    parameter int SETTLE_CYC = 10000
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic enable,
    output logic      settled
);
    logic [31:0] cnt_reg;

    always_ff @(posedge core_clk) begin
        if (!reset_n || !enable) begin
            cnt_reg <= 32'h0000_0000;
            settled <= 1'b0;
        end else if (cnt_reg < 32'(SETTLE_CYC - 1)) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end else begin
            settled <= 1'b1;
        end
    end
endmodule

// ===== rtl/lvd_ctrl.sv
// control logic of the supply-voltage monitor
// Functional notes
// (RL1) 4-bit level code in low nibble; codes 0..9 valid, others prohibited.
// (RL2) software writes zero to upper nibble of level register.
// (RL3) level changes only while monitor disabled; else level undefined.
// (RL4) monitor-caused reset keeps level register; other resets clear it.
// (RL5) reset mode: hold internal reset while supply below level.
// (RL6) interrupt mode: raise request while supply below level.
// (RL7) reset start: mask, level, enable, wait, check flag, select reset.
// (RL8) software waits settling time before trusting below-level flag.
// (RL9) mask interrupt before enabling, request may come at once.
// (RL10) selecting reset with supply above level gives no reset.
// (RL11) reset stop: write 00h, or clear action then enable.
// (RL12) any reset sets interrupt mask to one.
// (RL13) monitor reset-cause flag is bit 0 of reset-cause register.
// (RL14) interrupt start: mask, level, enable, wait, check, clear, unmask.
// (RL15) final step with vectored interrupts is global interrupt enable.
// (RL16) during settling a request and both flags may be set.
// (RL17) interrupt stop: write 00h or clear enable bit.
// (RL18) hovering supply may cause repeated resets in reset mode.
// (RL19) hovering supply may cause repeated requests in interrupt mode.
// (RL20) enable bit 7, action bit 1 (1=reset), read-only flag bit 0.
// (RL21) flag drives request only with enable=1 and action=0.
// (RL22) monitor reset sets its cause flag and keeps control register.
// (RL23) level register resets to zero on non-monitor resets.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module lvd_ctrl
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYC = LVD_SETTLE_CYC
) (
    input  wire logic            core_clk,
    input  wire logic            reset_n,
    input  wire logic            por_reset_n,
    input  wire logic            supply_below,
    input  wire lvd_pkg::lvd_bus_s bus,
    output logic [7:0]           rdata,
    output logic                 low_supply_irq,
    output logic                 monitor_reset_req,
    output logic                 settled
);
    import lvd_pkg::*;

    typedef enum logic [1:0] {LVD_IDLE, LVD_SETTLING, LVD_ACTIVE} lvd_state_e;

    lvd_state_e  state_reg;
    logic        monitor_enable;
    logic        action_select;
    logic        below_level_flag;
    logic [3:0]  level_select_reg;
    logic        monitor_irq_mask;
    logic        monitor_irq_pending;
    logic        monitor_reset_cause;
    logic        cmp_sync;
    logic        settle_done;
    logic        own_reset_reg;
    logic        irq_req;

    function automatic logic hit(input lvd_bus_s b, input logic [15:0] a);
        return b.addr == a;
    endfunction

    // kept out of the system reset so the request can follow the supply during its own reset
    lvd_sync u_sync (
        .core_clk (core_clk),
        .reset_n  (por_reset_n),
        .async_in (supply_below),
        .sync_out (cmp_sync)
    );

    lvd_settle #(.SETTLE_CYC(SETTLE_CYC)) u_settle (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .enable   (monitor_enable),
        .settled  (settle_done)
    );

    // remembers, for as long as the reset lasts, whether this monitor requested it
    always_ff @(posedge core_clk) begin
        if (!por_reset_n)
            own_reset_reg <= 1'b0;
        else if (!reset_n)
            own_reset_reg <= own_reset_reg | monitor_reset_req;
        else
            own_reset_reg <= 1'b0;
    end

    // control register survives a monitor reset
    always_ff @(posedge core_clk) begin
        if (!por_reset_n || (!reset_n && !own_reset_reg && !monitor_reset_req)) begin
            monitor_enable <= LVD_CTRL_RST[LVD_CTRL_EN_BIT]; // RL22
            action_select  <= LVD_CTRL_RST[LVD_CTRL_ACT_BIT];
        end else if (reset_n && bus.wr && hit(bus, LVD_CTRL_ADDR)) begin
            monitor_enable <= bus.wdata[LVD_CTRL_EN_BIT]; // RL20 RL11 RL17
            action_select  <= bus.wdata[LVD_CTRL_ACT_BIT]; // RL20
        end
    end

    // level register survives a monitor reset; upper nibble not stored
    always_ff @(posedge core_clk) begin
        if (!por_reset_n || (!reset_n && !own_reset_reg && !monitor_reset_req))
            level_select_reg <= LVD_LEVEL_RST; // RL4 RL23
        else if (reset_n && bus.wr && hit(bus, LVD_LEVEL_ADDR))
            level_select_reg <= bus.wdata[3:0]; // RL1 RL2 RL3
    end

    // flag reads zero while disabled; may rise during settling
    always_ff @(posedge core_clk) begin
        if (!reset_n)
            below_level_flag <= 1'b0;
        else
            below_level_flag <= monitor_enable & cmp_sync; // RL16 RL8
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n)
            state_reg <= LVD_IDLE;
        else begin
            case (state_reg)
                LVD_IDLE:     if (monitor_enable) state_reg <= LVD_SETTLING;
                LVD_SETTLING: if (!monitor_enable) state_reg <= LVD_IDLE;
                              else if (settle_done) state_reg <= LVD_ACTIVE;
                LVD_ACTIVE:   if (!monitor_enable) state_reg <= LVD_IDLE;
                default:      state_reg <= LVD_IDLE;
            endcase
        end
    end

    assign irq_req = below_level_flag & monitor_enable & ~action_select; // RL21 RL6 RL19

    // mask set on any reset; pending set wins over a clearing write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            monitor_irq_mask    <= 1'b1; // RL12 RL9
            monitor_irq_pending <= 1'b0;
        end else begin
            if (bus.wr && hit(bus, LVD_IRQ_ADDR)) begin
                monitor_irq_mask    <= bus.wdata[LVD_IRQ_MASK_BIT]; // RL14
                monitor_irq_pending <= bus.wdata[LVD_IRQ_PEND_BIT] | irq_req;
            end else if (irq_req) begin
                monitor_irq_pending <= 1'b1; // RL16
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n)
            low_supply_irq <= 1'b0;
        else
            low_supply_irq <= monitor_irq_pending & ~monitor_irq_mask; // RL6 RL15
    end

    // reset held across the monitor's own reset, so it tracks the supply level
    always_ff @(posedge core_clk) begin
        if (!por_reset_n)
            monitor_reset_req <= 1'b0;
        else
            monitor_reset_req <= monitor_enable & action_select & cmp_sync; // RL5 RL10 RL18
    end

    // cause flag cleared by a non-monitor reset, power-on, or a read of the cause register
    always_ff @(posedge core_clk) begin
        if (!por_reset_n)
            monitor_reset_cause <= 1'b0;
        else if (monitor_reset_req)
            monitor_reset_cause <= 1'b1; // RL22 RL13
        else if (!reset_n && !own_reset_reg)
            monitor_reset_cause <= 1'b0;
        else if (reset_n && bus.rd && hit(bus, LVD_CAUSE_ADDR))
            monitor_reset_cause <= 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n)
            settled <= 1'b0;
        else
            settled <= (state_reg == LVD_ACTIVE);
    end

    // read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!reset_n)
            rdata <= 8'h00;
        else if (bus.rd) begin
            if (hit(bus, LVD_CTRL_ADDR))
                rdata <= {monitor_enable, 5'h00, action_select, below_level_flag}; // RL20
            else if (hit(bus, LVD_LEVEL_ADDR))
                rdata <= {4'h0, level_select_reg};
            else if (hit(bus, LVD_IRQ_ADDR))
                rdata <= {6'h00, monitor_irq_mask, monitor_irq_pending};
            else if (hit(bus, LVD_CAUSE_ADDR))
                rdata <= {7'h00, monitor_reset_cause}; // RL13
            else
                rdata <= 8'h00;
        end else
            rdata <= 8'h00;
    end
endmodule

// ===== testbench/lvd_ctrl_checker.sv
// port assertions for the supply monitor control block
`timescale 1ns/100ps
module lvd_ctrl_checker
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYC = LVD_SETTLE_CYC
) (
    input wire logic             core_clk,
    input wire logic             reset_n,
    input wire logic             por_reset_n,
    input wire logic             supply_below,
    input wire lvd_pkg::lvd_bus_s bus,
    input wire logic [7:0]       rdata,
    input wire logic             low_supply_irq,
    input wire logic             monitor_reset_req,
    input wire logic             settled
);
    logic mask_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!por_reset_n);
    // shadow of the mask bit as software last left it
    always_ff @(posedge core_clk) begin
        if (!reset_n || !por_reset_n)
            mask_reg <= 1'b1;
        else if (bus.wr && bus.addr == LVD_IRQ_ADDR)
            mask_reg <= bus.wdata[LVD_IRQ_MASK_BIT];
    end
    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property ($past(bus.rd && bus.addr[15:2] != 14'h3fd4) |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    level_upper_a: assert property ($past(bus.rd && bus.addr == LVD_LEVEL_ADDR) |-> rdata[7:4] == 4'h0)
        else $error("level upper nibble not zero");
    ctrl_fixed_a: assert property ($past(bus.rd && bus.addr == LVD_CTRL_ADDR) |-> rdata[6:2] == 5'h00)
        else $error("control bits 6 to 2 not zero");
    mask_reset_a: assert property (!reset_n |=> !low_supply_irq)
        else $error("interrupt request right after reset");
    mask_gate_a: assert property (mask_reg [*2] |-> !low_supply_irq)
        else $error("interrupt request while masked");
    rst_cause_a: assert property (monitor_reset_req |-> $past(supply_below, 3))
        else $error("reset request without low supply");
    rst_release_a: assert property ((!supply_below) [*4] |-> !monitor_reset_req)
        else $error("reset request held with supply good");
    settle_reset_a: assert property (!reset_n |=> !settled)
        else $error("settled flag set right after reset");
endmodule
bind lvd_ctrl lvd_ctrl_checker #(.SETTLE_CYC(SETTLE_CYC)) lvd_ctrl_checker_i (
    .core_clk(core_clk), .reset_n(reset_n), .por_reset_n(por_reset_n),
    .supply_below(supply_below), .bus(bus), .rdata(rdata), .low_supply_irq(low_supply_irq),
    .monitor_reset_req(monitor_reset_req), .settled(settled));

// ===== testbench/lvd_supply_model.sv
// comparator and system reset logic around the monitor block
`timescale 1ns/100ps
module lvd_supply_model (
    input  wire logic low_supply,
    input  wire logic sys_rst_n,
    input  wire logic monitor_reset_req,
    output wire logic supply_below,
    output wire logic reset_n
);
    // comparator output is asynchronous, so it moves off the clock edge
    assign #3 supply_below = low_supply;
    assign reset_n = sys_rst_n & ~monitor_reset_req;
endmodule

// ===== testbench/lvd_ctrl_test.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/100ps
module lvd_ctrl_test;
    import lvd_pkg::*;
    localparam int SC = 20;
    logic       core_clk, por_reset_n, sys_rst_n, low_supply;
    logic       reset_n, supply_below, low_supply_irq, monitor_reset_req, settled;
    logic [7:0] rdata;
    lvd_bus_s   bus;
    int         errors, num_checks, cyc;
    lvd_supply_model lvd_supply_model_i (.low_supply(low_supply), .sys_rst_n(sys_rst_n),
        .monitor_reset_req(monitor_reset_req), .supply_below(supply_below), .reset_n(reset_n));
    lvd_ctrl #(.SETTLE_CYC(SC)) lvd_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
        .por_reset_n(por_reset_n), .supply_below(supply_below), .bus(bus), .rdata(rdata),
        .low_supply_irq(low_supply_irq), .monitor_reset_req(monitor_reset_req),
        .settled(settled));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            results();
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e)
            begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end
    endtask
    // settle past the edge so registered outputs have landed
    task automatic ticks(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(string n, logic [15:0] a, logic [7:0] e);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask
    task automatic t_regs();
        rd("ctrl", LVD_CTRL_ADDR, LVD_CTRL_RST);
        rd("level", LVD_LEVEL_ADDR, 8'h00);
        rd("irq", LVD_IRQ_ADDR, 8'h02);
        rd("cause", LVD_CAUSE_ADDR, 8'h00);
        wr(LVD_LEVEL_ADDR, 8'hf9);
        rd("level", LVD_LEVEL_ADDR, 8'h09);
        wr(LVD_CTRL_ADDR, 8'h7f);
        rd("ctrl", LVD_CTRL_ADDR, 8'h02);
        wr(LVD_CTRL_ADDR, 8'h00);
        rd("hole", 16'hff54, 8'h00);
    endtask
    task automatic t_irq();
        wr(LVD_LEVEL_ADDR, 8'h03);
        low_supply <= 1'b1;
        wr(LVD_CTRL_ADDR, 8'h80);
        ticks(SC);
        chk("early", 8'h00, {7'h0, settled});
        ticks(4);
        chk("settled", 8'h01, {7'h0, settled});
        rd("flag", LVD_CTRL_ADDR, 8'h81);
        chk("masked", 8'h00, {7'h0, low_supply_irq});
        wr(LVD_IRQ_ADDR, 8'h00);
        ticks(2);
        chk("irq", 8'h01, {7'h0, low_supply_irq});
        low_supply <= 1'b0;
        ticks(4);
        wr(LVD_IRQ_ADDR, 8'h00);
        ticks(2);
        chk("irq off", 8'h00, {7'h0, low_supply_irq});
        wr(LVD_CTRL_ADDR, 8'h00);
        low_supply <= 1'b1;
        ticks(6);
        rd("stopped", LVD_IRQ_ADDR, 8'h00);
        low_supply <= 1'b0;
    endtask
    task automatic t_rst();
        wr(LVD_IRQ_ADDR, 8'h02);
        wr(LVD_LEVEL_ADDR, 8'h05);
        wr(LVD_CTRL_ADDR, 8'h80);
        ticks(SC + 4);
        rd("flag", LVD_CTRL_ADDR, 8'h80);
        wr(LVD_CTRL_ADDR, 8'h82);
        ticks(6);
        chk("no rst", 8'h00, {7'h0, monitor_reset_req});
        low_supply <= 1'b1;
        ticks(25);
        chk("held", 8'h00, {7'h0, reset_n});
        low_supply <= 1'b0;
        ticks(5);
        chk("freed", 8'h01, {7'h0, reset_n});
        rd("ctrl kept", LVD_CTRL_ADDR, 8'h82);
        rd("level kept", LVD_LEVEL_ADDR, 8'h05);
        rd("mask", LVD_IRQ_ADDR, 8'h02);
        rd("cause", LVD_CAUSE_ADDR, 8'h01);
        rd("cause clr", LVD_CAUSE_ADDR, 8'h00);
        wr(LVD_CTRL_ADDR, 8'h00);
        // a power-on reset pulls the system reset as well
        por_reset_n <= 1'b0;
        sys_rst_n   <= 1'b0;
        repeat (3) @(posedge core_clk);
        por_reset_n <= 1'b1;
        sys_rst_n   <= 1'b1;
        ticks(1);
        rd("level por", LVD_LEVEL_ADDR, 8'h00);
    endtask
    initial begin
        errors = 0;
        num_checks = 0;
        cyc = 0;
        por_reset_n = 1'b0;
        sys_rst_n = 1'b0;
        low_supply = 1'b0;
        bus = '0;
        repeat (10) @(posedge core_clk);
        por_reset_n <= 1'b1;
        sys_rst_n <= 1'b1;
        ticks(1);
        t_regs();
        t_irq();
        t_rst();
        results();
    end
endmodule
